// file: core/ufi_pkg.sv
// Shared constants and types of the USB function interrupt flag block.
// Assumes a 32-bit Avalon-MM slave with word addresses given as byte offsets.
package ufi_pkg;
	// Register byte offsets
	localparam logic [5:0] OFS_FLAGS_CTRL = 6'h00;
	localparam logic [5:0] OFS_FLAGS_BULK = 6'h04;
	localparam logic [5:0] OFS_FLAGS_BUS = 6'h08;
	localparam logic [5:0] OFS_EN_CTRL = 6'h0C;
	localparam logic [5:0] OFS_EN_BULK = 6'h10;
	localparam logic [5:0] OFS_EN_BUS = 6'h14;
	localparam logic [5:0] OFS_SEL_CTRL = 6'h18;
	localparam logic [5:0] OFS_SEL_BULK = 6'h1C;
	localparam logic [5:0] OFS_SEL_BUS = 6'h20;
	// Control endpoint flag positions
	localparam int B_BUS_RESET = 7;
	localparam int B_CTRL_OUT_RX = 3;
	localparam int B_CTRL_IN_REQ = 2;
	localparam int B_CTRL_IN_TX = 1;
	localparam int B_SETUP_RX = 0;
	// Bulk endpoint flag positions
	localparam int B_BULK_ALL_EMPTY = 3;
	localparam int B_BULK_OUT_READY = 2;
	localparam int B_BULK_IN_REQ = 1;
	localparam int B_BULK_ANY_EMPTY = 0;
	// Bus state flag positions
	localparam int B_CLOCK_READY = 7;
	localparam int B_FRAME_START = 6;
	localparam int B_CONFIG_RX = 5;
	localparam int B_SUSPEND_STATE = 3;
	localparam int B_SUSPEND_EVENT = 2;
	localparam int B_CABLE_STATE = 1;
	localparam int B_CABLE_EVENT = 0;
	// Writable masks
	localparam logic [7:0] MASK_CTRL = 8'h8F;
	localparam logic [7:0] MASK_BULK = 8'h0F;
	localparam logic [7:0] MASK_BUS_FLAGS = 8'hE5;
	localparam logic [7:0] MASK_BUS_EN = 8'hE5;
	localparam logic [7:0] MASK_BUS_SEL = 8'hE1;
	// Clearable flags (status bits excluded)
	localparam logic [7:0] CLR_CTRL = 8'h8F;
	localparam logic [7:0] CLR_BULK = 8'h02;
	localparam logic [7:0] CLR_BUS = 8'hE5;
	// Reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_EN_CTRL = 8'h00;
	localparam logic [7:0] RST_EN_BULK = 8'h00;
	localparam logic [7:0] RST_EN_BUS = 8'h80;
	localparam logic [7:0] RST_SEL = 8'h00;
	// Clock settling times in microseconds per clock source
	localparam int CLK_HZ = 40_000_000;
	localparam int SETTLE_XTAL_US = 2000;
	localparam int SETTLE_EXT_US = 10;
	localparam int SETTLE_XTAL_CYC = (SETTLE_XTAL_US * (CLK_HZ / 1_000_000));
	localparam int SETTLE_EXT_CYC = (SETTLE_EXT_US * (CLK_HZ / 1_000_000));
	localparam int SETTLE_W = 20;

	typedef enum logic [2:0] {
		ST_STOPPED = 3'b001,
		ST_COUNTING = 3'b010,
		ST_RUNNING = 3'b100
	} ufi_settle_e;
endpackage

// file: core/ufi_events_if.sv
// Event strobes and level status passed from the USB engine to the flag logic.
// Assumes all signals synchronous to the module clock.
`timescale 1ns/1ps
interface ufi_events_if;
	logic [7:0] ctrl_set;
	logic [7:0] bulk_set;
	logic [7:0] bus_set;
	logic bulk_in_data_valid;
	logic bulk_in_any_empty;
	logic bulk_out_ready;
	logic suspend_state;
	logic cable_power_state;
	modport src (output ctrl_set, bulk_set, bus_set, bulk_in_data_valid,
		bulk_in_any_empty, bulk_out_ready, suspend_state, cable_power_state);
	modport dst (input ctrl_set, bulk_set, bus_set, bulk_in_data_valid,
		bulk_in_any_empty, bulk_out_ready, suspend_state, cable_power_state);
endinterface

// file: core/ufi_detect.sv
// Edge and event detector: turns engine pulses and levels into set strobes.
// Assumes engine pulses last one clock and levels are already synchronous.
`timescale 1ns/1ps
module ufi_detect (
	input wire logic clk,
	input wire logic rst,
	// Engine events
	input wire logic ctrl_out_ack,
	input wire logic ctrl_in_token,
	input wire logic ctrl_in_fifo_valid,
	input wire logic ctrl_in_ack,
	input wire logic setup_ack,
	input wire logic bus_reset_seen,
	input wire logic bulk_in_token,
	input wire logic [1:0] bulk_in_fifo_valid,
	input wire logic [1:0] bulk_out_fifo_valid,
	input wire logic frame_start_seen,
	input wire logic set_config_seen,
	input wire logic suspend_in,
	input wire logic cable_in,
	input wire logic clock_ready_pulse,
	// To flag logic
	ufi_events_if.src ev
);
	typedef struct packed {
		logic suspend_d;
		logic cable_d;
	} ufi_det_s;
	ufi_det_s q_r;
	ufi_det_s q_nxt;

	// Previous levels for change detection
	always_comb begin
		q_nxt = q_r;
		q_nxt.suspend_d = suspend_in;
		q_nxt.cable_d = cable_in;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Control endpoint set strobes
	always_comb begin
		ev.ctrl_set = '0;
		ev.ctrl_set[ufi_pkg::B_CTRL_OUT_RX] = ctrl_out_ack; // R01
		ev.ctrl_set[ufi_pkg::B_CTRL_IN_REQ] = ctrl_in_token & ~ctrl_in_fifo_valid; // R02
		ev.ctrl_set[ufi_pkg::B_CTRL_IN_TX] = ctrl_in_ack; // R03
		ev.ctrl_set[ufi_pkg::B_SETUP_RX] = setup_ack; // R04
		ev.ctrl_set[ufi_pkg::B_BUS_RESET] = bus_reset_seen; // R23
	end

	// Bulk endpoint strobe and FIFO levels
	always_comb begin
		ev.bulk_set = '0;
		ev.bulk_set[ufi_pkg::B_BULK_IN_REQ] = bulk_in_token & ~(|bulk_in_fifo_valid); // R08
		ev.bulk_in_data_valid = |bulk_in_fifo_valid;
		ev.bulk_in_any_empty = ~(&bulk_in_fifo_valid); // R09
		ev.bulk_out_ready = |bulk_out_fifo_valid; // R07
	end

	// Bus state strobes; a change of either level is an event
	always_comb begin
		ev.bus_set = '0;
		ev.bus_set[ufi_pkg::B_CLOCK_READY] = clock_ready_pulse;
		ev.bus_set[ufi_pkg::B_FRAME_START] = frame_start_seen; // R13
		ev.bus_set[ufi_pkg::B_CONFIG_RX] = set_config_seen; // R14
		ev.bus_set[ufi_pkg::B_SUSPEND_EVENT] = suspend_in ^ q_r.suspend_d; // R16
		ev.bus_set[ufi_pkg::B_CABLE_EVENT] = cable_in ^ q_r.cable_d; // R18
		ev.suspend_state = suspend_in; // R15
		ev.cable_power_state = cable_in; // R17
	end
endmodule

// file: core/ufi_top.sv
// USB function interrupt flags, enables and line selects with an Avalon-MM slave.
// Assumes engine strobes synchronous to CLK; reads answer one cycle after request.
// Notes on behaviour
// R01: Control-OUT data acked sets receive-complete flag.
// R02: IN token on empty control-IN FIFO sets transfer-request flag.
// R03: Control-IN data acked by host sets transmit-complete flag.
// R04: Acked 8-byte setup command sets setup-received flag.
// R05: Writing 0 clears a flag; writing 1 does nothing.
// R06: Bulk-IN all-empty is inverse of bulk-IN data valid; resets to 1.
// R07: Bulk-OUT ready is 1 while either endpoint 2 FIFO holds data.
// R08: IN token with both bulk-IN FIFOs empty sets transfer-request flag.
// R09: Bulk-IN any-empty is 1 unless both FIFOs hold data; resets 1.
// R10: FIFO status bits follow occupancy only, writes ignored.
// R11: After module stop release, count settle time then set clock-ready.
// R12: Clock-ready logic runs during interface software reset.
// R13: Start-of-frame packet sets frame-start flag.
// R14: Set_Configuration request sets configuration-received flag.
// R15: Suspend status bit shows bus state, never interrupts.
// R16: Suspend/resume change sets event flag, reported on wake-up line only.
// R17: Cable power status bit shows presence, never interrupts.
// R18: Cable attach or removal sets cable-power event flag.
// R19: Line asserts only for set flag with enable 1; clock-ready enable resets 1.
// R20: Select 0 routes to line A, select 1 to line B.
// R21: Bus-status enable register accessible while module stop two is 1.
// R22: Suspend/resume enable gates only the wake-up line.
// R23: Detected bus reset sets bus-reset flag.
// R24: Lines are active low levels, held while any routed flag enabled.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module ufi_top (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,

	// Avalon-MM slave
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,

	// Control endpoint events
	input wire logic CTRL_OUT_ACK,
	input wire logic CTRL_IN_TOKEN,
	input wire logic CTRL_IN_FIFO_VALID,
	input wire logic CTRL_IN_ACK,
	input wire logic SETUP_ACK,
	input wire logic BUS_RESET_SEEN,

	// Bulk endpoint events
	input wire logic BULK_IN_TOKEN,
	input wire logic [1:0] BULK_IN_FIFO_VALID,
	input wire logic [1:0] BULK_OUT_FIFO_VALID,

	// Bus status
	input wire logic FRAME_START_SEEN,
	input wire logic SET_CONFIG_SEEN,
	input wire logic SUSPEND_STATE,
	input wire logic CABLE_POWER_STATE,

	// Clocking control
	input wire logic USB_MODULE_STOP_TWO,
	input wire logic USB_INTERFACE_SOFT_RESET,
	input wire logic CLOCK_SOURCE_EXT,

	// Interrupt lines, active low
	output logic USB_IRQ_LINE_A_N,
	output logic USB_IRQ_LINE_B_N,
	output logic WAKEUP_IRQ_LINE_N
);
	// Settle counts; a bench may shorten them to keep runs brief
	parameter int SETTLE_XTAL_CYC = ufi_pkg::SETTLE_XTAL_CYC;
	parameter int SETTLE_EXT_CYC = ufi_pkg::SETTLE_EXT_CYC;

	typedef struct packed {
		// Event flags, one byte per register
		logic [7:0] flags_ctrl;
		logic [7:0] flags_bulk;
		logic [7:0] flags_bus;

		// Enables; only clock-ready starts set
		logic [7:0] en_ctrl;
		logic [7:0] en_bulk;
		logic [7:0] en_bus;

		// Line selects, 0 picks line A
		logic [7:0] sel_ctrl;
		logic [7:0] sel_bulk;
		logic [7:0] sel_bus;

		// Clock settle timer
		ufi_pkg::ufi_settle_e settle;
		logic [ufi_pkg::SETTLE_W-1:0] count;

		// Read data path
		logic rd_pending;
		logic [31:0] rdata;

		// Line drivers, registered so they never glitch
		logic irq_a_n;
		logic irq_b_n;
		logic wake_n;
	} ufi_state_s;

	// Current and next state
	ufi_state_s s_r;
	ufi_state_s s_nxt;

	// Glue between the detector and the flag logic
	logic clock_ready_pulse;
	logic wr_lo;
	ufi_events_if ev ();

	// Byte write helper: clear-only for flags, set bits win over clear
	function automatic logic [7:0] flag_update(input logic [7:0] cur, input logic [7:0] set,
		input logic [7:0] clr_mask, input logic wr, input logic [7:0] wdata);
		logic [7:0] v;
		v = cur;
		// Status bits sit outside the mask and never clear
		if (wr) begin
			v = cur & (wdata | ~clr_mask); // R05
		end
		// An event in the same cycle as the clear is not lost
		flag_update = v | set;
	endfunction

	// Route flags to the two general lines through select bits
	function automatic logic [1:0] route(input logic [7:0] req, input logic [7:0] sel);
		logic to_a;
		logic to_b;
		to_a = |(req & ~sel);
		to_b = |(req & sel);
		route = {to_b, to_a}; // R20
	endfunction

	// Event detection kept apart from the register file
	ufi_detect u_detect (
		.clk(CLK),
		.rst(RST),
		.ctrl_out_ack(CTRL_OUT_ACK),
		.ctrl_in_token(CTRL_IN_TOKEN),
		.ctrl_in_fifo_valid(CTRL_IN_FIFO_VALID),
		.ctrl_in_ack(CTRL_IN_ACK),
		.setup_ack(SETUP_ACK),
		.bus_reset_seen(BUS_RESET_SEEN),
		.bulk_in_token(BULK_IN_TOKEN),
		.bulk_in_fifo_valid(BULK_IN_FIFO_VALID),
		.bulk_out_fifo_valid(BULK_OUT_FIFO_VALID),
		.frame_start_seen(FRAME_START_SEEN),
		.set_config_seen(SET_CONFIG_SEEN),
		.suspend_in(SUSPEND_STATE),
		.cable_in(CABLE_POWER_STATE),
		.clock_ready_pulse(clock_ready_pulse),
		.ev(ev)
	);

	// Only the low byte holds register data
	// Upper lanes hold nothing, so a write without lane 0 is dropped
	assign wr_lo = AVS_WRITE & AVS_BYTEENABLE[0];

	// Writes complete at once; reads wait one cycle for registered data
	always_comb begin
		AVS_WAITREQUEST = AVS_READ & ~s_r.rd_pending;
		AVS_READDATA = s_r.rdata;
		USB_IRQ_LINE_A_N = s_r.irq_a_n;
		USB_IRQ_LINE_B_N = s_r.irq_b_n;
		WAKEUP_IRQ_LINE_N = s_r.wake_n;
	end

	// Pulse when the settling counter finishes
	assign clock_ready_pulse = (s_r.settle == ufi_pkg::ST_COUNTING) &&
		(s_r.count == '0);

	// Next state of the whole block
	always_comb begin
		logic [7:0] live_bulk;
		logic [7:0] live_bus;
		logic [7:0] rd_byte;
		logic [1:0] r_ctrl;
		logic [1:0] r_bulk;
		logic [1:0] r_bus;
		live_bulk = '0;
		live_bus = '0;
		rd_byte = '0;
		r_ctrl = '0;
		r_bulk = '0;
		r_bus = '0;
		s_nxt = s_r;

		// Settling counter ignores soft reset; only module stop restarts it
		case (s_r.settle)
			ufi_pkg::ST_STOPPED: begin
				if (!USB_MODULE_STOP_TWO) begin // R11 R12
					s_nxt.settle = ufi_pkg::ST_COUNTING;
					// Load the count for the chosen clock source
					s_nxt.count = CLOCK_SOURCE_EXT ?
						ufi_pkg::SETTLE_W'(SETTLE_EXT_CYC - 1) :
						ufi_pkg::SETTLE_W'(SETTLE_XTAL_CYC - 1);
				end
			end

			ufi_pkg::ST_COUNTING: begin
				// Stopping again throws the partial count away
				if (USB_MODULE_STOP_TWO) begin
					s_nxt.settle = ufi_pkg::ST_STOPPED;
				end else if (s_r.count == '0) begin
					s_nxt.settle = ufi_pkg::ST_RUNNING; // R11
				end else begin
					s_nxt.count = s_r.count - 1'b1;
				end
			end

			ufi_pkg::ST_RUNNING: begin
				if (USB_MODULE_STOP_TWO) begin
					s_nxt.settle = ufi_pkg::ST_STOPPED;
				end
			end

			default: begin
				s_nxt.settle = ufi_pkg::ST_STOPPED;
			end
		endcase

		// Event flags; soft reset holds engine flags but not clock-ready
		// Control endpoint flags
		s_nxt.flags_ctrl = flag_update(s_r.flags_ctrl,
			USB_INTERFACE_SOFT_RESET ? 8'h00 : ev.ctrl_set, ufi_pkg::CLR_CTRL,
			wr_lo && AVS_ADDRESS == ufi_pkg::OFS_FLAGS_CTRL, AVS_WRITEDATA[7:0]);

		// Bulk transfer-request flag; status bits are live, not stored
		s_nxt.flags_bulk = flag_update(s_r.flags_bulk,
			USB_INTERFACE_SOFT_RESET ? 8'h00 : ev.bulk_set, ufi_pkg::CLR_BULK,
			wr_lo && AVS_ADDRESS == ufi_pkg::OFS_FLAGS_BULK, AVS_WRITEDATA[7:0]);

		// Bus state flags; clock-ready keeps counting through soft reset
		s_nxt.flags_bus = flag_update(s_r.flags_bus,
			USB_INTERFACE_SOFT_RESET ? (ev.bus_set & 8'h80) : ev.bus_set, // R12
			ufi_pkg::CLR_BUS,
			wr_lo && AVS_ADDRESS == ufi_pkg::OFS_FLAGS_BUS, AVS_WRITEDATA[7:0]);

		// Enables and selects, plain read/write
		if (wr_lo) begin
			if (AVS_ADDRESS == ufi_pkg::OFS_EN_CTRL) begin
				s_nxt.en_ctrl = AVS_WRITEDATA[7:0] & ufi_pkg::MASK_CTRL;
			end else if (AVS_ADDRESS == ufi_pkg::OFS_EN_BULK) begin
				s_nxt.en_bulk = AVS_WRITEDATA[7:0] & ufi_pkg::MASK_BULK;
			end else if (AVS_ADDRESS == ufi_pkg::OFS_EN_BUS) begin
				// Reachable whatever the module stop state
				s_nxt.en_bus = AVS_WRITEDATA[7:0] & ufi_pkg::MASK_BUS_EN; // R21
			end else if (AVS_ADDRESS == ufi_pkg::OFS_SEL_CTRL) begin
				s_nxt.sel_ctrl = AVS_WRITEDATA[7:0] & ufi_pkg::MASK_CTRL;
			end else if (AVS_ADDRESS == ufi_pkg::OFS_SEL_BULK) begin
				s_nxt.sel_bulk = AVS_WRITEDATA[7:0] & ufi_pkg::MASK_BULK;
			end else if (AVS_ADDRESS == ufi_pkg::OFS_SEL_BUS) begin
				s_nxt.sel_bus = AVS_WRITEDATA[7:0] & ufi_pkg::MASK_BUS_SEL;
			end
		end

		// Live status bits merged with stored flags; writes never reach them
		live_bulk = s_r.flags_bulk & ufi_pkg::CLR_BULK; // R10
		live_bulk[ufi_pkg::B_BULK_ALL_EMPTY] = ~ev.bulk_in_data_valid; // R06
		live_bulk[ufi_pkg::B_BULK_OUT_READY] = ev.bulk_out_ready; // R07
		live_bulk[ufi_pkg::B_BULK_ANY_EMPTY] = ev.bulk_in_any_empty; // R09

		// Bus state levels shown as they are, never stored
		live_bus = s_r.flags_bus & ufi_pkg::CLR_BUS;
		live_bus[ufi_pkg::B_SUSPEND_STATE] = ev.suspend_state; // R15
		live_bus[ufi_pkg::B_CABLE_STATE] = ev.cable_power_state; // R17

		// Read decode; unmapped offsets read zero
		if (AVS_ADDRESS == ufi_pkg::OFS_FLAGS_CTRL) begin
			rd_byte = s_r.flags_ctrl;
		end else if (AVS_ADDRESS == ufi_pkg::OFS_FLAGS_BULK) begin
			rd_byte = live_bulk;
		end else if (AVS_ADDRESS == ufi_pkg::OFS_FLAGS_BUS) begin
			rd_byte = live_bus;
		end else if (AVS_ADDRESS == ufi_pkg::OFS_EN_CTRL) begin
			rd_byte = s_r.en_ctrl;
		end else if (AVS_ADDRESS == ufi_pkg::OFS_EN_BULK) begin
			rd_byte = s_r.en_bulk;
		end else if (AVS_ADDRESS == ufi_pkg::OFS_EN_BUS) begin
			rd_byte = s_r.en_bus;
		end else if (AVS_ADDRESS == ufi_pkg::OFS_SEL_CTRL) begin
			rd_byte = s_r.sel_ctrl;
		end else if (AVS_ADDRESS == ufi_pkg::OFS_SEL_BULK) begin
			rd_byte = s_r.sel_bulk;
		end else if (AVS_ADDRESS == ufi_pkg::OFS_SEL_BUS) begin
			rd_byte = s_r.sel_bus;
		end

		// Capture on the first read cycle; the second cycle hands it over
		s_nxt.rd_pending = AVS_READ & ~s_r.rd_pending;
		if (AVS_READ && !s_r.rd_pending) begin
			s_nxt.rdata = {24'h00_0000, rd_byte};
		end

		// Requests: flag and enable both needed; bus state bits masked out, bulk status levels kept
		r_ctrl = route(s_r.flags_ctrl & s_r.en_ctrl, s_r.sel_ctrl); // R19
		r_bulk = route(live_bulk & s_r.en_bulk, s_r.sel_bulk); // R19
		// Suspend event and both state bits never reach the general lines
		r_bus = route(s_r.flags_bus & s_r.en_bus & ufi_pkg::MASK_BUS_SEL,
			s_r.sel_bus); // R22 R15 R17

		// Lines go low one cycle after a request appears
		s_nxt.irq_a_n = ~(r_ctrl[0] | r_bulk[0] | r_bus[0]); // R24
		s_nxt.irq_b_n = ~(r_ctrl[1] | r_bulk[1] | r_bus[1]); // R24

		// Wake-up line has its own enable and no select
		s_nxt.wake_n = ~(s_r.flags_bus[ufi_pkg::B_SUSPEND_EVENT] &
			s_r.en_bus[ufi_pkg::B_SUSPEND_EVENT]); // R16 R22
	end

	// Register the whole state
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			// Flags start clear
			s_r.flags_ctrl <= ufi_pkg::RST_FLAGS;
			s_r.flags_bulk <= ufi_pkg::RST_FLAGS;
			s_r.flags_bus <= ufi_pkg::RST_FLAGS;

			// Only the clock-ready enable starts set
			s_r.en_ctrl <= ufi_pkg::RST_EN_CTRL;
			s_r.en_bulk <= ufi_pkg::RST_EN_BULK;
			s_r.en_bus <= ufi_pkg::RST_EN_BUS; // R19

			// All events start on line A
			s_r.sel_ctrl <= ufi_pkg::RST_SEL;
			s_r.sel_bulk <= ufi_pkg::RST_SEL;
			s_r.sel_bus <= ufi_pkg::RST_SEL;

			// Timer idles until the module is started
			s_r.settle <= ufi_pkg::ST_STOPPED;
			s_r.count <= '0;

			// No read in flight
			s_r.rd_pending <= 1'b0;
			s_r.rdata <= 32'h0000_0000;

			// Lines released
			s_r.irq_a_n <= 1'b1;
			s_r.irq_b_n <= 1'b1;
			s_r.wake_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// file: testbench/ufi_monitor.sv
// Port checker for the USB interrupt flag block.
// Assumes it is bound to ufi_top and sees nothing but its ports.
`timescale 1ns/1ps
module ufi_monitor (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register bus
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// Level inputs
	input wire logic [1:0] BULK_IN_FIFO_VALID,
	input wire logic [1:0] BULK_OUT_FIFO_VALID,
	input wire logic SUSPEND_STATE,
	input wire logic CABLE_POWER_STATE,
	// Lines
	input wire logic USB_IRQ_LINE_A_N,
	input wire logic USB_IRQ_LINE_B_N,
	input wire logic WAKEUP_IRQ_LINE_N
);
	logic [2:0] quiet_r;
	logic [2:0] quiet_nxt;
	logic [5:0] lvl_r;
	logic [5:0] lvl;
	logic rd_done;
	logic rd_bulk;
	logic rd_bus;
	// Status reads are judged only once the levels have settled, hiding detector lag
	assign lvl = {BULK_IN_FIFO_VALID, BULK_OUT_FIFO_VALID, SUSPEND_STATE, CABLE_POWER_STATE};
	assign rd_done = AVS_READ && !AVS_WAITREQUEST;
	assign rd_bulk = rd_done && quiet_r >= 3'h6 && AVS_ADDRESS == ufi_pkg::OFS_FLAGS_BULK;
	assign rd_bus = rd_done && quiet_r >= 3'h6 && AVS_ADDRESS == ufi_pkg::OFS_FLAGS_BUS;
	always_comb begin
		quiet_nxt = (quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1;
		if (lvl_r != lvl)
			quiet_nxt = 3'h0;
	end
	// Settle counter
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			quiet_r <= 3'h0;
			lvl_r <= 6'h00;
		end else begin
			quiet_r <= quiet_nxt;
			lvl_r <= lvl;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wr_nowait_a: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
		else $error("write was stalled");
	rd_wait_a: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("read stalled past one cycle");
	unmapped_zero_a: assert property (rd_done && AVS_ADDRESS > 6'h20 |-> AVS_READDATA == 0)
		else $error("unmapped read not zero");
	all_empty_a: assert property (rd_bulk |-> AVS_READDATA[3] == (BULK_IN_FIFO_VALID == 2'b00))
		else $error("all-empty bit wrong");
	out_ready_a: assert property (rd_bulk |-> AVS_READDATA[2] == |BULK_OUT_FIFO_VALID)
		else $error("out-ready bit wrong");
	any_empty_a: assert property (rd_bulk |-> AVS_READDATA[0] == !(&BULK_IN_FIFO_VALID))
		else $error("any-empty bit wrong");
	suspend_bit_a: assert property (rd_bus |-> AVS_READDATA[3] == SUSPEND_STATE)
		else $error("suspend bit wrong");
	cable_bit_a: assert property (rd_bus |-> AVS_READDATA[1] == CABLE_POWER_STATE)
		else $error("cable bit wrong");
	cover property (rd_bulk);
	cover property ($fell(WAKEUP_IRQ_LINE_N));
	cover property ($fell(USB_IRQ_LINE_B_N));
endmodule

bind ufi_top ufi_monitor ufi_monitor_inst (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .BULK_IN_FIFO_VALID(BULK_IN_FIFO_VALID),
	.BULK_OUT_FIFO_VALID(BULK_OUT_FIFO_VALID), .SUSPEND_STATE(SUSPEND_STATE),
	.CABLE_POWER_STATE(CABLE_POWER_STATE), .USB_IRQ_LINE_A_N(USB_IRQ_LINE_A_N),
	.USB_IRQ_LINE_B_N(USB_IRQ_LINE_B_N), .WAKEUP_IRQ_LINE_N(WAKEUP_IRQ_LINE_N));

// file: testbench/ufi_host_model.sv
// Stand-in for host traffic as the USB engine reports it to the flag block.
// Assumes one command at a time from the bench, after reset.
`timescale 1ns/1ps
module ufi_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command from the bench
	input wire logic go,
	input wire logic [2:0] sel,
	// One-cycle event pulses
	output logic [7:0] pulse
);
	// Each transaction ends in one pulse; events never overlap
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulse <= 8'h00;
		end else begin
			pulse <= go ? (8'h01 << sel) : 8'h00;
		end
	end
endmodule

// file: testbench/ufi_top_bench.sv
// Self-checking bench of the USB interrupt flag block.
// Assumes the partner model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module ufi_top_bench;
	logic CLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, go = 0;
	logic [5:0] AVS_ADDRESS = 0;
	logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, rs;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic [2:0] sel = 0;
	logic [7:0] pls, rq[$];
	logic [1:0] BULK_IN_FIFO_VALID = 0, BULK_OUT_FIFO_VALID = 0;
	logic CTRL_IN_FIFO_VALID = 0, SUSPEND_STATE = 0, CABLE_POWER_STATE = 0, AVS_WAITREQUEST;
	logic USB_MODULE_STOP_TWO = 1, USB_INTERFACE_SOFT_RESET = 0, CLOCK_SOURCE_EXT = 0;
	logic USB_IRQ_LINE_A_N, USB_IRQ_LINE_B_N, WAKEUP_IRQ_LINE_N;
	int failures = 0, samples_checked = 0, cyc = 0;
	logic [5:0] ea [8] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h04, 6'h08, 6'h08};
	int eb [8] = '{3, 2, 1, 0, 7, 1, 6, 5};
	logic [5:0] ra [5] = '{6'h0C, 6'h10, 6'h14, 6'h18, 6'h3C};
	logic [7:0] rm [5] = '{8'h8F, 8'h0F, 8'hE5, 8'h8F, 8'h00};
	always #12.5 CLK = ~CLK;
	ufi_host_model ufi_host_model_inst (.clk(CLK), .rst(RST), .go(go), .sel(sel), .pulse(pls));
	ufi_top #(.SETTLE_XTAL_CYC(6), .SETTLE_EXT_CYC(4)) ufi_top_inst (.CLK(CLK), .RST(RST),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.CTRL_OUT_ACK(pls[0]), .CTRL_IN_TOKEN(pls[1]), .CTRL_IN_FIFO_VALID(CTRL_IN_FIFO_VALID),
		.CTRL_IN_ACK(pls[2]), .SETUP_ACK(pls[3]), .BUS_RESET_SEEN(pls[4]),
		.BULK_IN_TOKEN(pls[5]), .BULK_IN_FIFO_VALID(BULK_IN_FIFO_VALID),
		.BULK_OUT_FIFO_VALID(BULK_OUT_FIFO_VALID), .FRAME_START_SEEN(pls[6]),
		.SET_CONFIG_SEEN(pls[7]), .SUSPEND_STATE(SUSPEND_STATE),
		.CABLE_POWER_STATE(CABLE_POWER_STATE), .USB_MODULE_STOP_TWO(USB_MODULE_STOP_TWO),
		.USB_INTERFACE_SOFT_RESET(USB_INTERFACE_SOFT_RESET), .CLOCK_SOURCE_EXT(CLOCK_SOURCE_EXT),
		.USB_IRQ_LINE_A_N(USB_IRQ_LINE_A_N), .USB_IRQ_LINE_B_N(USB_IRQ_LINE_B_N),
		.WAKEUP_IRQ_LINE_N(WAKEUP_IRQ_LINE_N));
	function automatic logic [7:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Request held until the edge that sees waitrequest low
	task automatic bus(input logic rd, input logic [5:0] a, input logic [7:0] d);
		@(posedge CLK);
		AVS_READ <= rd;
		AVS_WRITE <= !rd;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h0, d};
		if (rd) rq.push_back(d);
		// Waitrequest is taken at the rising edge, before the slave updates
		do begin
			@(posedge CLK);
		end while (AVS_WAITREQUEST !== 1'b0);
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	task automatic ev(input int k);
		@(posedge CLK);
		go <= 1'b1;
		sel <= k[2:0];
		@(posedge CLK);
		go <= 1'b0;
		repeat (4) @(posedge CLK);
	endtask
	task automatic chkl(input int n, input logic [2:0] e);
		repeat (n) @(posedge CLK);
		@(negedge CLK);
		samples_checked++;
		if ({USB_IRQ_LINE_A_N, USB_IRQ_LINE_B_N, WAKEUP_IRQ_LINE_N} !== e) begin
			failures++;
			$display("FAIL %0t lines %h exp %h", $time, {USB_IRQ_LINE_A_N,
				USB_IRQ_LINE_B_N, WAKEUP_IRQ_LINE_N}, e);
		end
	endtask
	// Read results against the oldest expectation
	always @(posedge CLK) begin
		if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
			samples_checked++;
			if (rq.size() == 0 || AVS_READDATA !== {24'h0, rq[0]}) begin
				failures++;
				$display("FAIL %0t got %h exp %h", $time, AVS_READDATA, rq[0]);
			end
			if (rq.size() > 0) void'(rq.pop_front());
		end
	end
	// Hang guard, well above the few hundred cycles the sequence needs
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		logic [7:0] e, b;
		rs = 32'd49;
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		// Reset values, then masked read-back with the module still stopped
		bus(1, 6'h14, 8'h80);
		bus(1, 6'h04, 8'h09);
		for (int i = 0; i < 5; i++) begin
			e = rnd();
			bus(0, ra[i], e);
			bus(1, ra[i], e & rm[i]);
			bus(0, ra[i], 8'h00);
		end
		// Each event sets its flag, ignores writes of 1, clears on 0
		for (int i = 0; i < 8; i++) begin
			b = (ea[i] == 6'h04) ? 8'h09 : 8'h00;
			ev(i);
			bus(1, ea[i], b | (8'h01 << eb[i]));
			bus(0, ea[i], 8'hFF);
			bus(1, ea[i], b | (8'h01 << eb[i]));
			bus(0, ea[i], ~(8'h01 << eb[i]));
			bus(1, ea[i], b);
		end
		CTRL_IN_FIFO_VALID <= 1'b1;
		ev(1);
		bus(1, 6'h00, 8'h00);
		// Frame-start routed by its select bit and gated by its enable
		bus(0, 6'h14, 8'h40);
		ev(6);
		chkl(1, 3'b011);
		bus(0, 6'h20, 8'h40);
		chkl(2, 3'b101);
		bus(0, 6'h14, 8'h00);
		chkl(2, 3'b111);
		bus(0, 6'h08, 8'hBF);
		// Suspend change goes to the wake-up line whatever the selects say
		bus(0, 6'h20, 8'hFF);
		bus(0, 6'h14, 8'h04);
		SUSPEND_STATE <= 1'b1;
		chkl(5, 3'b110);
		bus(1, 6'h08, 8'h0C);
		bus(0, 6'h08, 8'hFB);
		chkl(2, 3'b111);
		SUSPEND_STATE <= 1'b0;
		chkl(5, 3'b110);
		bus(0, 6'h08, 8'hFB);
		bus(0, 6'h14, 8'h01);
		bus(0, 6'h20, 8'h00);
		CABLE_POWER_STATE <= 1'b1;
		chkl(5, 3'b011);
		bus(1, 6'h08, 8'h03);
		bus(0, 6'h08, 8'hFE);
		chkl(2, 3'b111);
		bus(0, 6'h14, 8'h00);
		// Bulk status follows random FIFO occupancy and ignores writes
		for (int i = 0; i < 8; i++) begin
			e = rnd();
			BULK_IN_FIFO_VALID <= e[1:0];
			BULK_OUT_FIFO_VALID <= e[3:2];
			repeat (8) @(posedge CLK);
			bus(0, 6'h04, 8'h00);
			bus(1, 6'h04, {4'h0, e[1:0] == 2'b00, |e[3:2], 1'b0, ~&e[1:0]});
		end
		// Bulk all-empty level reaches line B through its select
		BULK_IN_FIFO_VALID <= 2'b00;
		bus(0, 6'h10, 8'h08);
		bus(0, 6'h1C, 8'h08);
		chkl(2, 3'b101);
		bus(0, 6'h10, 8'h00);
		chkl(2, 3'b111);
		// Clock-ready after the short settle count, despite soft reset
		bus(0, 6'h14, 8'h80);
		USB_INTERFACE_SOFT_RESET <= 1'b1;
		CLOCK_SOURCE_EXT <= 1'b1;
		USB_MODULE_STOP_TWO <= 1'b0;
		chkl(2, 3'b111);
		chkl(8, 3'b011);
		bus(1, 6'h08, 8'h82);
		tally_and_finish();
	end
endmodule
